// ===== rtl/cvp_map.svh
// Constants for the converter serial port control block
`ifndef CVP_MAP_SVH
`define CVP_MAP_SVH

// System clock
`define CVP_CLK_PERIOD_NS 5

// Conversion timing
`define CVP_CONV_MAX_NS 10000
`define CVP_FULL_EDGES 5'h14
`define CVP_SHORT_EDGES 5'h13
`define CVP_OSC_HALF_CYC ((`CVP_CONV_MAX_NS / int'(`CVP_FULL_EDGES)) / (2 * `CVP_CLK_PERIOD_NS))
`define CVP_LATE_WIN_NS 30
`define CVP_LATE_CYC ((`CVP_LATE_WIN_NS + `CVP_CLK_PERIOD_NS - 1) / `CVP_CLK_PERIOD_NS)
`define CVP_SYNC_LAT 5'h02
`define CVP_WIN_MAX 4'hf

// Serial word layout
`define CVP_WORD_BITS 16
`define CVP_DATA_BITS 14
`define CVP_LEAD_ZEROS 2'h0
`define CVP_LAST_BIT 5'h0f
`define CVP_MSB_POS 15

`endif

// ===== rtl/cvp_pkg.sv
// Types shared by the converter serial port control block
`include "cvp_map.svh"

package cvp_pkg;

   typedef logic [`CVP_DATA_BITS-1:0] cvp_code_t;

   // Received word crossing from the transmit link domain
   typedef struct packed {
      logic tog;
      cvp_code_t word;
   } cvp_xfer_t;

   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic [4:0] cnt;
      logic done;
      logic [`CVP_WORD_BITS-1:0] shift;
      cvp_code_t in_latch;
      logic tog;
   } cvp_link_t;

   typedef struct packed {
      logic trig_s1, trig_s2, trig_d;
      logic aclk_s1, aclk_s2;
      logic int_s1, int_s2;
      logic gate_s1, gate_s2;
      logic tfs_s1, tfs_s2, tfs_d;
      logic dac_load_strobe_s1, dac_load_strobe_s2, dac_load_strobe_d;
      logic tog_s1, tog_s2, tog_d;
      logic clk_d;
      logic [6:0] osc_cnt;
      logic osc_lvl;
      logic busy;
      logic hold;
      logic late;
      logic [4:0] edge_all;
      logic [3:0] win;
      logic rfs_low;
      logic fell_seen;
      logic [4:0] bit_cnt;
      logic [`CVP_WORD_BITS-1:0] shreg;
      logic in_frame;
      logic dac_load_strobe_held;
      cvp_code_t hold_word;
      cvp_code_t dac_latch;
   } cvp_sys_t;

endpackage

// ===== rtl/cvp_dac_link.sv
// Transmit link shifter and input holding latch, on the host shift clock
`timescale 1ns/1ps
`default_nettype none
`include "cvp_map.svh"

module cvp_dac_link
   import cvp_pkg::*;
(
   // Link pins
   input wire logic transmit_shift_clock,
   input wire logic transmit_frame_strobe_n,
   input wire logic transmit_serial_in,
   // Reset from the system domain
   input wire logic rst,
   // Word toward the system domain
   output cvp_xfer_t xfer
);

   cvp_link_t s;
   cvp_link_t next_s;

   // Bits are taken on falling shift clock edges while the strobe is low
   always_comb begin
      next_s = s;
      next_s.rst_s1 = rst;
      next_s.rst_s2 = s.rst_s1;
      if (s.rst_s2) begin
         next_s.cnt = '0;
         next_s.done = 1'b0;
         // Toggle must match the cleared system side, else a false word follows
         next_s.tog = 1'b0;
      end else if (transmit_frame_strobe_n) begin
         next_s.cnt = '0;
         next_s.done = 1'b0;
      end else if (!s.done) begin
         next_s.shift = {s.shift[`CVP_WORD_BITS-2:0], transmit_serial_in};
         if (s.cnt == `CVP_LAST_BIT) begin
            // Leading two bits are dropped, only the data part is latched
            next_s.in_latch = {s.shift[`CVP_DATA_BITS-2:0], transmit_serial_in};
            next_s.tog = ~s.tog;
            next_s.done = 1'b1;
            next_s.cnt = '0;
         end else begin
            next_s.cnt = s.cnt + 5'h01;
         end
      end
   end

   // No reset pin on this side; the clock may stop between frames
   always_ff @(negedge transmit_shift_clock) begin
      s <= next_s;
   end

   assign xfer.tog = s.tog;
   assign xfer.word = s.in_latch;

   property p_link_word;
      @(negedge transmit_shift_clock) disable iff (s.rst_s2)
      (!transmit_frame_strobe_n && !s.done && s.cnt == `CVP_LAST_BIT)
         |=> (s.tog != $past(s.tog)) && s.done;
   endproperty
   a_link_word: assert property (p_link_word) else $error("word not latched on bit 16");

   property p_link_quiet;
      @(negedge transmit_shift_clock) disable iff (s.rst_s2)
      (s.done && !transmit_frame_strobe_n) |=> $stable(s.in_latch) && $stable(s.tog);
   endproperty
   a_link_quiet: assert property (p_link_quiet) else $error("latch moved after word");

endmodule
`default_nettype wire

// ===== rtl/cvp_port.sv
// Converter control: conversion timing, receive serial port and DAC latching
// Overview of operation
// - Trigger rising edge puts track/hold into hold and starts conversion.
// - Trigger is asynchronous; it is synchronised before use.
// - Control at ground gates receive clock once both conversion and transfer end; at negative supply continuous.
// - One transmit bit captured per falling transmit clock edge while strobe low.
// - Transmit bits go into an input latch separate from the DAC latch.
// - Falling DAC load strobe copies input latch into DAC latch; code ignores a fall from transmit strobe fall until the word arrives.
// - Internal oscillator selected by strap; 20 edges fit within 10 us.
// - Receive clock comes from the active ADC clock, optionally gated off.
// - External or continuous clock conversion lasts 19 or 20 rising edges.
// - Trigger within 30 ns before a rising edge gives 20 edges.
// - Internal oscillator in gated mode always takes 19 rising edges.
// - ADC results and DAC codes are 14-bit two's complement.
// - ADC word is 16 bits: two zeros then result, MSB first.
// - Receive frame low at start; bits change on rise, valid on fall.
// - Load strobe low through a transfer updates DAC on 16th edge.
`timescale 1ns/1ps
`default_nettype none
`include "cvp_map.svh"

module cvp_port
   import cvp_pkg::*;
(
   // System clock, reset and enable
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // Conversion control and ADC clock pins
   input wire logic conversion_trigger,
   input wire logic adc_clk_pin,
   input wire logic adc_clk_internal,
   input wire logic rclk_gated,
   // Converter core
   input wire cvp_code_t conv_result,
   output logic track_hold,
   output logic conv_busy,
   // Receive frame strobe, open drain, active low
   input wire logic receive_frame_strobe_n_in,
   output logic receive_frame_strobe_n_out,
   output logic receive_frame_strobe_n_oe,
   // Receive serial data, open drain
   input wire logic receive_serial_out_in,
   output logic receive_serial_out_out,
   output logic receive_serial_out_oe,
   // Receive shift clock, open drain
   input wire logic receive_shift_clock_in,
   output logic receive_shift_clock_out,
   output logic receive_shift_clock_oe,
   // Transmit link pins
   input wire logic transmit_shift_clock,
   input wire logic transmit_frame_strobe_n,
   input wire logic transmit_serial_in,
   input wire logic dac_load_strobe_n,
   // DAC code
   output cvp_code_t dac_code
);

   localparam logic [6:0] OSC_HALF = 7'(`CVP_OSC_HALF_CYC);
   localparam logic [4:0] LATE_CYC = 5'(`CVP_LATE_CYC);

   cvp_sys_t s;
   cvp_sys_t next_s;
   cvp_xfer_t xfer;

   logic clk_lvl;
   logic aclk_rise;
   logic aclk_fall;
   logic trig_rise;
   logic int_gated;
   logic late_now;
   logic [4:0] target;
   logic tfs_fall;
   logic dac_load_strobe_fall;
   logic word_ev;

   cvp_dac_link u_link (
      .transmit_shift_clock(transmit_shift_clock),
      .transmit_frame_strobe_n(transmit_frame_strobe_n),
      .transmit_serial_in(transmit_serial_in),
      .rst(rst),
      .xfer(xfer)
   );

   assign clk_lvl = s.int_s2 ? s.osc_lvl : s.aclk_s2;
   assign aclk_rise = clk_lvl & ~s.clk_d;
   assign aclk_fall = ~clk_lvl & s.clk_d;
   assign trig_rise = s.trig_s2 & ~s.trig_d;
   assign int_gated = s.int_s2 & s.gate_s2;
   assign tfs_fall = ~s.tfs_s2 & s.tfs_d;
   assign dac_load_strobe_fall = ~s.dac_load_strobe_s2 & s.dac_load_strobe_d;
   assign word_ev = s.tog_s2 ^ s.tog_d;
   // Late only decided on the first edge; gated internal clock restarts in phase
   assign late_now = (s.edge_all == 5'h00)
      ? ((({1'b0, s.win} + `CVP_SYNC_LAT) < LATE_CYC) && !int_gated)
      : s.late;
   assign target = late_now ? `CVP_FULL_EDGES : `CVP_SHORT_EDGES;

   always_comb begin
      next_s = s;
      // Pin synchronisers
      next_s.trig_s1 = conversion_trigger;
      next_s.trig_s2 = s.trig_s1;
      next_s.trig_d = s.trig_s2;
      next_s.aclk_s1 = adc_clk_pin;
      next_s.aclk_s2 = s.aclk_s1;
      next_s.int_s1 = adc_clk_internal;
      next_s.int_s2 = s.int_s1;
      next_s.gate_s1 = rclk_gated;
      next_s.gate_s2 = s.gate_s1;
      next_s.tfs_s1 = transmit_frame_strobe_n;
      next_s.tfs_s2 = s.tfs_s1;
      next_s.tfs_d = s.tfs_s2;
      next_s.dac_load_strobe_s1 = dac_load_strobe_n;
      next_s.dac_load_strobe_s2 = s.dac_load_strobe_s1;
      next_s.dac_load_strobe_d = s.dac_load_strobe_s2;
      next_s.tog_s1 = xfer.tog;
      next_s.tog_s2 = s.tog_s1;
      next_s.tog_d = s.tog_s2;
      next_s.clk_d = clk_lvl;

      // Internal oscillator; stopped between conversions in gated mode
      if (int_gated && !s.busy) begin
         next_s.osc_cnt = '0;
         next_s.osc_lvl = 1'b0;
      end else if (s.osc_cnt == OSC_HALF - 7'h01) begin
         next_s.osc_cnt = '0;
         next_s.osc_lvl = ~s.osc_lvl;
      end else begin
         next_s.osc_cnt = s.osc_cnt + 7'h01;
      end

      // Conversion start; triggers during a conversion are ignored
      if (trig_rise && !s.busy) begin
         next_s.busy = 1'b1;
         next_s.hold = 1'b1;
         next_s.edge_all = '0;
         next_s.win = '0;
         next_s.late = 1'b0;
         next_s.rfs_low = 1'b1;
         next_s.fell_seen = 1'b0;
         next_s.bit_cnt = '0;
         next_s.shreg = {`CVP_LEAD_ZEROS, conv_result};
      end else begin
         if (s.busy) begin
            if (s.win != `CVP_WIN_MAX) begin
               next_s.win = s.win + 4'h1;
            end
            if (aclk_rise) begin
               next_s.edge_all = s.edge_all + 5'h01;
               next_s.late = late_now;
               if (s.edge_all + 5'h01 == target) begin
                  next_s.busy = 1'b0;
                  next_s.hold = 1'b0;
               end
            end
         end
         // Shift out on rising edges, only after the first falling edge
         if (s.rfs_low) begin
            if (aclk_fall) begin
               next_s.fell_seen = 1'b1;
            end
            if (aclk_rise && s.fell_seen) begin
               if (s.bit_cnt == `CVP_LAST_BIT) begin
                  next_s.rfs_low = 1'b0;
               end else begin
                  next_s.shreg = {s.shreg[`CVP_WORD_BITS-2:0], 1'b0};
                  next_s.bit_cnt = s.bit_cnt + 5'h01;
               end
            end
         end
      end

      // DAC side frame tracking
      if (tfs_fall) begin
         next_s.in_frame = 1'b1;
         next_s.dac_load_strobe_held = ~s.dac_load_strobe_s2;
      end else if (s.in_frame && s.dac_load_strobe_s2) begin
         next_s.dac_load_strobe_held = 1'b0;
      end
      if (word_ev) begin
         // Word stays stable for a full frame on the link side
         next_s.hold_word = xfer.word;
         next_s.in_frame = 1'b0;
         if (s.dac_load_strobe_held && !s.dac_load_strobe_s2) begin
            next_s.dac_latch = xfer.word;
         end
      end else if (dac_load_strobe_fall && !s.in_frame) begin
         // A strobe falling mid-frame is deliberately ignored
         next_s.dac_latch = s.hold_word;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign track_hold = s.hold;
   assign conv_busy = s.busy;
   assign dac_code = s.dac_latch;
   assign receive_frame_strobe_n_out = 1'b0;
   assign receive_frame_strobe_n_oe = s.rfs_low;
   assign receive_serial_out_out = 1'b0;
   assign receive_serial_out_oe = s.rfs_low & ~s.shreg[`CVP_MSB_POS];
   assign receive_shift_clock_out = 1'b0;
   // Released line floats high through the pull-up, so only low is driven
   assign receive_shift_clock_oe = ~s.clk_d & (~s.gate_s2 | s.busy | s.rfs_low);

   // Assertion helper: falling receive clock edges inside a frame
   logic [4:0] fall_cnt;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fall_cnt <= '0;
      end else if (ce) begin
         if (trig_rise && !s.busy) begin
            fall_cnt <= '0;
         end else if (s.rfs_low && aclk_fall) begin
            fall_cnt <= fall_cnt + 5'h01;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst || !ce);

   property p_start_hold;
      (trig_rise && !s.busy) |=> s.hold && s.busy && s.rfs_low;
   endproperty
   a_start_hold: assert property (p_start_hold) else $error("no hold on trigger");

   property p_trig_sync;
      (!s.busy && !s.trig_s2 && $rose(conversion_trigger)) |-> ##[2:4] s.busy;
   endproperty
   a_trig_sync: assert property (p_trig_sync) else $error("trigger not taken");

   property p_gated_off;
      (s.gate_s2 && !s.busy && !s.rfs_low) |-> !receive_shift_clock_oe;
   endproperty
   a_gated_off: assert property (p_gated_off) else $error("clock not gated off");

   property p_continuous;
      !s.gate_s2 |-> (receive_shift_clock_oe == !s.clk_d);
   endproperty
   a_continuous: assert property (p_continuous) else $error("clock not continuous");

   property p_conv_len;
      $fell(s.busy) |-> (s.edge_all == (s.late ? `CVP_FULL_EDGES : `CVP_SHORT_EDGES));
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("bad conversion length");

   property p_late;
      (s.busy && aclk_rise && s.edge_all == 5'h00 && !int_gated
         && (({1'b0, s.win} + `CVP_SYNC_LAT) < LATE_CYC)) |=> s.late;
   endproperty
   a_late: assert property (p_late) else $error("late trigger not stretched");

   property p_gated_int;
      (int_gated && $fell(s.busy)) |-> (s.edge_all == `CVP_SHORT_EDGES) && !s.late;
   endproperty
   a_gated_int: assert property (p_gated_int) else $error("gated internal not 19");

   property p_frame_len;
      $fell(s.rfs_low) |-> (fall_cnt == 5'h10);
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame not 16 bits");

   property p_lead_zero;
      $rose(s.rfs_low) |-> receive_serial_out_oe ##1 (receive_serial_out_oe || !s.rfs_low);
   endproperty
   a_lead_zero: assert property (p_lead_zero) else $error("first bit not zero");

   property p_dac_only_on_load;
      $changed(s.dac_latch) |-> $past(word_ev) || $past(dac_load_strobe_fall);
   endproperty
   a_dac_only_on_load: assert property (p_dac_only_on_load) else $error("DAC moved");

   property p_dac_load_strobe_fall;
      (dac_load_strobe_fall && !word_ev && !s.in_frame) |=> (s.dac_latch == $past(s.hold_word));
   endproperty
   a_dac_load_strobe_fall: assert property (p_dac_load_strobe_fall) else $error("load strobe ignored");

   property p_held_update;
      (word_ev && s.dac_load_strobe_held && !s.dac_load_strobe_s2) |=> (s.dac_latch == $past(xfer.word));
   endproperty
   a_held_update: assert property (p_held_update) else $error("no update on bit 16");

   property p_osc_bound;
      s.osc_cnt < OSC_HALF;
   endproperty
   a_osc_bound: assert property (p_osc_bound) else $error("oscillator count overrun");

endmodule
`default_nettype wire

// ===== verif/cvp_host_model.sv
// Host serial port model: DAC word sender and ADC word receiver
`timescale 1ns/1ps
`default_nettype none

module cvp_host_model (
   // Transmit link toward the device
   output logic lk_clk,
   output logic lk_frm_n,
   output logic lk_dat,
   // Receive lines as seen on the wires
   input wire logic rx_frm_w,
   input wire logic rx_clk_w,
   input wire logic rx_dat_w,
   output logic [15:0] rx_word,
   output logic [4:0] rx_count
);
   // Frame level before the current time step
   logic frm_q;

   initial begin
      lk_clk = 1'b1;
      lk_frm_n = 1'b1;
      lk_dat = 1'b0;
      rx_word = 16'h0000;
      rx_count = 5'h00;
   end

   // Link clock idles high between frames, 125 ns period inside them
   task automatic edge_pair();
      #62.5 lk_clk = 1'b0;
      #62.5 lk_clk = 1'b1;
   endtask

   task automatic send_word(input logic [15:0] w);
      lk_frm_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         lk_dat = w[i];
         edge_pair();
      end
      // Strobe high on one edge so the next word frames afresh
      lk_frm_n = 1'b1;
      // Released data line shows no stale bit
      lk_dat = ~w[0];
      edge_pair();
   endtask

   task automatic rx_clear();
      rx_count = 5'h00;
   endtask

   always @(rx_frm_w) frm_q <= rx_frm_w;

   // A clock fall together with the frame fall is not a bit edge
   always @(negedge rx_clk_w) begin
      if (frm_q === 1'b0) begin
         rx_word = {rx_word[14:0], rx_dat_w};
         rx_count = rx_count + 5'h01;
      end
   end
endmodule

`default_nettype wire

// ===== verif/cvp_port_test.sv
// Self-checking bench for the converter serial port control block
`timescale 1ns/1ps
`default_nettype none

module cvp_port_test
   import cvp_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst, conversion_trigger, adc_clk_pin, adc_clk_internal, rclk_gated;
   logic dac_load_strobe_n, track_hold, conv_busy;
   logic frm_out, frm_oe, dat_out, dat_oe, rck_out, rck_oe;
   cvp_code_t conv_result, dac_code;
   wire lk_clk, lk_frm_n, lk_dat;
   wire [15:0] rx_word;
   wire [4:0] rx_count;
   // Open-drain lines with pull-ups
   wire rx_frm_w = frm_oe ? frm_out : 1'b1;
   wire rx_dat_w = dat_oe ? dat_out : 1'b1;
   wire rx_clk_w = rck_oe ? rck_out : 1'b1;
   int n_errors = 0;
   int check_count = 0;
   int ext_cnt = 0;
   int rck_cnt = 0;

   cvp_port u_cvp_port (
      .clk_sys(clk_sys), .rst(rst), .ce(1'b1),
      .conversion_trigger(conversion_trigger), .adc_clk_pin(adc_clk_pin),
      .adc_clk_internal(adc_clk_internal), .rclk_gated(rclk_gated),
      .conv_result(conv_result), .track_hold(track_hold), .conv_busy(conv_busy),
      .receive_frame_strobe_n_in(rx_frm_w), .receive_frame_strobe_n_out(frm_out),
      .receive_frame_strobe_n_oe(frm_oe), .receive_serial_out_in(rx_dat_w),
      .receive_serial_out_out(dat_out), .receive_serial_out_oe(dat_oe),
      .receive_shift_clock_in(rx_clk_w), .receive_shift_clock_out(rck_out),
      .receive_shift_clock_oe(rck_oe), .transmit_shift_clock(lk_clk),
      .transmit_frame_strobe_n(lk_frm_n), .transmit_serial_in(lk_dat),
      .dac_load_strobe_n(dac_load_strobe_n), .dac_code(dac_code)
   );

   cvp_host_model u_cvp_host_model (
      .lk_clk(lk_clk), .lk_frm_n(lk_frm_n), .lk_dat(lk_dat),
      .rx_frm_w(rx_frm_w), .rx_clk_w(rx_clk_w), .rx_dat_w(rx_dat_w),
      .rx_word(rx_word), .rx_count(rx_count)
   );

   always #2.5 clk_sys = ~clk_sys;

   // External ADC clock, 2 MHz, even duty, unrelated phase
   initial begin
      adc_clk_pin = 1'b0;
      #1;
      forever #250 adc_clk_pin = ~adc_clk_pin;
   end

   always @(posedge adc_clk_pin) ext_cnt++;
   always @(posedge rx_clk_w) rck_cnt++;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (n_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic run_conv(input cvp_code_t res, input logic late, input logic [15:0] edges);
      int e0, r0, cyc;
      @(negedge clk_sys);
      conv_result = res;
      u_cvp_host_model.rx_clear();
      if (!adc_clk_internal && late) begin
         // Lands 21 ns before a rising ADC clock edge
         @(negedge adc_clk_pin);
         repeat (46) @(negedge clk_sys);
      end else if (!adc_clk_internal) begin
         @(posedge adc_clk_pin);
         @(negedge clk_sys);
      end
      e0 = ext_cnt;
      r0 = rck_cnt;
      conversion_trigger = 1'b1;
      cyc = 0;
      while (conv_busy !== 1'b1 && cyc < 5) begin
         @(negedge clk_sys);
         cyc++;
      end
      check(conv_busy, 1'b1);
      check(track_hold, 1'b1);
      check(rx_frm_w, 1'b0);
      repeat (100) @(negedge clk_sys);
      conversion_trigger = 1'b0;
      repeat (100) @(negedge clk_sys);
      // Second rise while busy must change nothing
      conversion_trigger = 1'b1;
      cyc = 0;
      while (conv_busy === 1'b1 && cyc < 3000) begin
         @(negedge clk_sys);
         cyc++;
      end
      conversion_trigger = 1'b0;
      check(16'(adc_clk_internal ? rck_cnt - r0 : ext_cnt - e0), edges);
      check(16'(cyc + 203 <= 2000), 16'h0001);
      check(track_hold, 1'b0);
      check(rx_word, {2'b00, res});
      check(rx_count, 16'h0010);
      check(rx_frm_w, 1'b1);
      r0 = rck_cnt;
      repeat (400) @(negedge clk_sys);
      check(16'(rck_cnt == r0), {15'h0000, rclk_gated});
   endtask

   task automatic t_conv_early();
      run_conv(14'h1fff, 1'b0, 16'h0013);
   endtask

   task automatic t_conv_late();
      rclk_gated = 1'b1;
      run_conv(14'h2000, 1'b1, 16'h0014);
   endtask

   task automatic t_conv_osc();
      adc_clk_internal = 1'b1;
      run_conv(14'h2a55, 1'b0, 16'h0013);
   endtask

   task automatic t_dac_two_step();
      u_cvp_host_model.send_word({2'b11, 14'h1555});
      repeat (10) @(negedge clk_sys);
      check(dac_code, 14'h0000);
      dac_load_strobe_n = 1'b0;
      repeat (10) @(negedge clk_sys);
      check(dac_code, 14'h1555);
   endtask

   task automatic t_dac_held();
      u_cvp_host_model.send_word({2'b00, 14'h2abc});
      repeat (10) @(negedge clk_sys);
      check(dac_code, 14'h2abc);
      dac_load_strobe_n = 1'b1;
   endtask

   task automatic t_dac_abort();
      repeat (10) @(negedge clk_sys);
      dac_load_strobe_n = 1'b0;
      fork
         u_cvp_host_model.send_word({2'b01, 14'h0f0f});
         begin
            repeat (200) @(negedge clk_sys);
            dac_load_strobe_n = 1'b1;
         end
      join
      repeat (10) @(negedge clk_sys);
      check(dac_code, 14'h2abc);
      dac_load_strobe_n = 1'b0;
      repeat (10) @(negedge clk_sys);
      check(dac_code, 14'h0f0f);
   endtask

   initial begin
      rst = 1'b1;
      conversion_trigger = 1'b0;
      adc_clk_internal = 1'b0;
      // Strap only at ground or negative supply, never the test setting
      rclk_gated = 1'b0;
      dac_load_strobe_n = 1'b1;
      conv_result = 14'h0000;
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      // Link side sees reset only on its own clock edges
      @(negedge clk_sys);
      rst = 1'b1;
      repeat (3) u_cvp_host_model.edge_pair();
      @(negedge clk_sys);
      rst = 1'b0;
      // Strobe-high link edges settle the link counters
      u_cvp_host_model.edge_pair();
      u_cvp_host_model.edge_pair();
      t_conv_early();
      t_conv_late();
      t_conv_osc();
      t_dac_two_step();
      t_dac_held();
      t_dac_abort();
      stop_test();
   end

   // Whole run needs about 42 us
   initial begin
      #400000;
      n_errors++;
      stop_test();
   end
endmodule

`default_nettype wire
